// ---- sbh_bus_if.sv ----
// processor end of the multiplexed system bus: issue, arbitration, hand-over
`timescale 1ns/100ps
module sbh_bus_if (
  // clock and reset
  input  wire logic                         clock_in,
  input  wire logic                         arst_n_in,
  // core request port
  input  wire logic                         req_valid_in,
  input  wire sbh_pkg::sbh_req_s            req_in,
  output logic                              req_ready_out,
  // core write data stream
  input  wire logic                         wr_valid_in,
  input  wire logic [sbh_pkg::AD_W-1:0]     wr_data_in,
  input  wire logic                         wr_last_in,
  output logic                              wr_ready_out,
  // read response to the core
  output logic                              rsp_valid_out,
  output logic [sbh_pkg::AD_W-1:0]          rsp_data_out,
  output logic                              rsp_last_out,
  output logic                              rsp_error_out,
  // status
  output logic                              slave_state_out,
  output logic                              read_pending_out,
  // shared bus pins
  input  wire logic [sbh_pkg::AD_W-1:0]     addr_data_bus_in,
  output logic [sbh_pkg::AD_W-1:0]          addr_data_bus_out,
  output logic                              addr_data_bus_oe_out,
  input  wire logic [sbh_pkg::CMD_W-1:0]    command_bus_in,
  output logic [sbh_pkg::CMD_W-1:0]         command_bus_out,
  output logic                              command_bus_oe_out,
  // handshake pins, all active low
  output logic                              proc_valid_n_out,
  input  wire logic                         ext_valid_n_in,
  input  wire logic                         ext_accept_n_in,
  input  wire logic                         ext_bus_request_n_in,
  output logic                              proc_owner_n_out,
  output logic                              proc_bus_request_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // input capture

  sbh_pkg::sbh_pin_in_s pin_raw;
  sbh_pkg::sbh_pin_in_s pin;

  always_comb begin
    pin_raw.ad       = addr_data_bus_in;
    pin_raw.cmd      = command_bus_in;
    pin_raw.valid_n  = ext_valid_n_in;
    pin_raw.accept_n = ext_accept_n_in;
    pin_raw.ext_bus_request_n_n   = ext_bus_request_n_in;
  end

  // whole bundle shares one latency so cycle alignment of the bus is kept;
  // the price is two cycles before any pin change is acted on, so the agent
  // has to hold accept through the address cycle it admits
  sbh_sync #(
    .W       (sbh_pkg::PIN_IN_W),
    .RST_VAL (sbh_pkg::RST_PIN_IN)
  ) sbh_sync_inst (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .d_in      (pin_raw),
    .q_out     (pin)
  );

  logic ext_valid;
  logic accepted;
  logic ext_req;
  logic ext_data;
  logic ext_last;

  always_comb begin
    ext_valid = !pin.valid_n;
    accepted  = !pin.accept_n;
    ext_req   = !pin.ext_bus_request_n_n;
    ext_data  = ext_valid && sbh_pkg::is_data_cycle(pin.cmd);
    ext_last  = ext_data &&
                (pin.cmd[sbh_pkg::CODE_W-1:0] == sbh_pkg::LAST_DATA_ID);
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state

  sbh_pkg::sbh_state_e state;
  sbh_pkg::sbh_state_e next_state;
  sbh_pkg::sbh_req_s   held;
  sbh_pkg::sbh_req_s   next_held;
  logic                pend;
  logic                next_pend;
  logic                rd_pend;
  logic                next_rd_pend;
  sbh_pkg::sbh_pin_out_s pout;
  sbh_pkg::sbh_pin_out_s next_pout;
  // set by a read issue, so the next finished external request hands back
  logic                handed;
  logic                next_handed;

  // owner indication and both bus drivers are let go in the same cycle
  function automatic sbh_pkg::sbh_pin_out_s release_pins(
    input sbh_pkg::sbh_pin_out_s p
  );
    sbh_pkg::sbh_pin_out_s r;
    r         = p;
    r.owner_n = 1'b1;
    r.oe      = 1'b0;
    return r;
  endfunction

  logic take_req;
  logic done_ext;
  logic issue;
  logic give_up;

  always_comb begin
    // a read may not start while one is still unanswered
    req_ready_out = (state == sbh_pkg::ST_IDLE) && !pend && !ext_req &&
                    !(req_in.is_read && rd_pend);
    take_req      = req_valid_in && req_ready_out;
    wr_ready_out  = (state == sbh_pkg::ST_DATA);
    // an external request is complete once its last data element is seen;
    // address-only requests of the agent are not tracked and keep slave state
    done_ext      = (state == sbh_pkg::ST_SLAVE) && ext_last;
  end

  ////////////////////////////////////////////////////////////////////////////
  // issue and release decisions

  // accept wins over a bus request seen in the same cycle: the request is
  // then finished first and the agent gets the buses after its last word
  always_comb begin
    issue   = (state == sbh_pkg::ST_ADDR) && accepted;
    give_up = (state == sbh_pkg::ST_ADDR) && !accepted && ext_req;
  end

  always_comb begin
    next_state   = state;
    next_held    = held;
    next_pend    = pend;
    next_rd_pend = rd_pend;
    next_handed  = handed;
    next_pout    = pout;
    next_pout.valid_n = 1'b1;

    case (state)
      sbh_pkg::ST_IDLE: begin
        next_pout.oe      = 1'b1;
        next_pout.owner_n = 1'b0;
        next_pout.proc_bus_request_n_n  = 1'b1;
        if (ext_req) begin
          // release before starting anything new
          next_state        = sbh_pkg::ST_SLAVE;
          next_pout         = release_pins(next_pout);
        end else if (pend || take_req) begin
          // a held request goes out again with its code and address kept
          if (take_req) begin
            next_held = req_in;
            next_pend = 1'b1;
          end
          next_state        = sbh_pkg::ST_ADDR;
          next_pout.ad      = take_req ? req_in.addr : held.addr;
          next_pout.cmd     = sbh_pkg::addr_cmd(take_req ? req_in.code
                                                         : held.code);
          next_pout.valid_n = 1'b0;
        end
      end

      sbh_pkg::ST_ADDR: begin
        if (issue) begin
          // the address cycle now on the bus is the single issue cycle
          next_pout.valid_n = 1'b1;
          if (held.is_read) begin
            next_pend         = 1'b0;
            next_rd_pend      = 1'b1;
            next_handed       = 1'b1;
            next_state        = sbh_pkg::ST_SLAVE;
            next_pout         = release_pins(next_pout);
          end else begin
            next_state = sbh_pkg::ST_DATA;
          end
        end else if (give_up) begin
          // give up the unissued request, it stays held for a retry
          next_state        = sbh_pkg::ST_SLAVE;
          next_pout         = release_pins(next_pout);
        end else begin
          // no accept yet: the same address cycle stays on the bus
          next_pout.valid_n = 1'b0;
        end
      end

      sbh_pkg::ST_DATA: begin
        // a gap in the core stream just leaves valid off for that cycle;
        // a bus request of the agent waits until the last word is out
        if (wr_valid_in) begin
          next_pout.ad      = wr_data_in;
          next_pout.cmd     = sbh_pkg::data_cmd(wr_last_in);
          next_pout.valid_n = 1'b0;
          if (wr_last_in) begin
            next_pend  = 1'b0;
            next_state = sbh_pkg::ST_IDLE;
          end
        end
      end

      sbh_pkg::ST_SLAVE: begin
        next_pout         = release_pins(next_pout);
        // ask for the buses back while a request is waiting to go out
        next_pout.proc_bus_request_n_n  = !pend;
        if (done_ext) begin
          if (rd_pend) begin
            next_rd_pend = 1'b0;
          end
          next_handed = 1'b0;
          // after a read hand-over the buses come back even if the agent
          // asks again; it then wins them through the normal arbitration
          if (!ext_req || handed) begin
            // master again; drivers turn on one cycle later so the agent's
            // last drive cannot overlap ours
            next_state        = sbh_pkg::ST_IDLE;
            next_pout.owner_n = 1'b0;
            next_pout.proc_bus_request_n_n  = 1'b1;
          end
        end
      end

      default: begin
        next_state = sbh_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state         <= sbh_pkg::ST_IDLE;
      held          <= '0;
      pend          <= 1'b0;
      rd_pend       <= 1'b0;
      handed        <= 1'b0;
      pout.ad       <= sbh_pkg::RST_AD;
      pout.cmd      <= sbh_pkg::RST_CMD;
      pout.oe       <= sbh_pkg::RST_BUS_OE;
      pout.valid_n  <= sbh_pkg::RST_VALID_N;
      pout.owner_n  <= sbh_pkg::RST_OWNER_N;
      pout.proc_bus_request_n_n   <= sbh_pkg::RST_PROC_BUS_REQUEST_N_N;
    end else begin
      state   <= next_state;
      held    <= next_held;
      pend    <= next_pend;
      rd_pend <= next_rd_pend;
      handed  <= next_handed;
      pout    <= next_pout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read response path

  logic                     next_rsp_valid;
  logic [sbh_pkg::AD_W-1:0] next_rsp_data;
  logic                     next_rsp_last;
  logic                     next_rsp_error;

  // only data seen in slave state while a read is open belongs to the core;
  // the error flag rides with each element, the core decides what to do
  always_comb begin
    next_rsp_valid = (state == sbh_pkg::ST_SLAVE) && rd_pend && ext_data;
    next_rsp_data  = next_rsp_valid ? pin.ad : rsp_data_out;
    next_rsp_last  = next_rsp_valid && ext_last;
    next_rsp_error = next_rsp_valid && pin.cmd[sbh_pkg::DATA_ERR_BIT];
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= sbh_pkg::RST_AD;
      rsp_last_out  <= 1'b0;
      rsp_error_out <= 1'b0;
    end else begin
      rsp_valid_out <= next_rsp_valid;
      rsp_data_out  <= next_rsp_data;
      rsp_last_out  <= next_rsp_last;
      rsp_error_out <= next_rsp_error;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs, every one straight from a flip-flop

  always_comb begin
    addr_data_bus_out      = pout.ad;
    addr_data_bus_oe_out   = pout.oe;
    command_bus_out        = pout.cmd;
    command_bus_oe_out     = pout.oe;
    proc_valid_n_out       = pout.valid_n;
    proc_owner_n_out       = pout.owner_n;
    proc_bus_request_n_out = pout.proc_bus_request_n_n;
    // slave indication is the owner flop itself, so it cannot disagree
    slave_state_out        = pout.owner_n;
    read_pending_out       = rd_pend;
  end

endmodule

// ---- sbh_pkg.sv ----
// constants, types and helpers for the system bus handshake block
//
// Functional notes
// - valid command with top bit 0 is an address cycle with a command code
// - valid command with top bit 1 is a data cycle with a data identifier
// - in master state the processor strobes valid on every valid bus cycle
// - processor repeats the address cycle until accept conditions are met
// - exactly one issue cycle per request, inside its address cycle
// - external bus request releases the bus, but accept wins in the issue cycle and an accepted write sends all its data first
// - a request released unissued is retried after the external request
// - processor has a request output asking for the buses back
// - outputs come from flip-flops, inputs are captured in flip-flops
// - master state left only by arbitration loss or read hand-over
// - arbitration: request, owner released, master again when request ends
// - after issuing a read the owner indication drops on its own
// - after hand-over master is taken back when next external request ends
// - external request ends with arbitration request idle: back to master
// - every data element but the last carries not-last id, last carries last
// - at most one read outstanding, next read waits for the response
package sbh_pkg;

  localparam int AD_W        = 32;
  localparam int CMD_W       = 5;
  localparam int CODE_W      = 4;
  localparam int CMD_TYPE_BIT = 4;
  localparam int SYNC_STAGES = 2;

  // data identifier codes; bit 2 flags erroneous response data
  localparam logic [CODE_W-1:0] NOT_LAST_DATA_ID = 4'h0;
  localparam logic [CODE_W-1:0] LAST_DATA_ID     = 4'h1;
  localparam int                DATA_ERR_BIT     = 2;

  // reset values of the pin outputs
  localparam logic          RST_VALID_N  = 1'b1;
  localparam logic          RST_OWNER_N  = 1'b0;
  localparam logic          RST_PROC_BUS_REQUEST_N_N   = 1'b1;
  localparam logic          RST_BUS_OE   = 1'b1;
  localparam logic [AD_W-1:0]  RST_AD    = 32'h0000_0000;
  localparam logic [CMD_W-1:0] RST_CMD   = 5'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DATA  = 3'b011,
    ST_SLAVE = 3'b010
  } sbh_state_e;

  typedef struct packed {
    logic              is_read;
    logic [CODE_W-1:0] code;
    logic [AD_W-1:0]   addr;
  } sbh_req_s;

  typedef struct packed {
    logic [AD_W-1:0]  ad;
    logic [CMD_W-1:0] cmd;
    logic             valid_n;
    logic             accept_n;
    logic             ext_bus_request_n_n;
  } sbh_pin_in_s;

  typedef struct packed {
    logic [AD_W-1:0]  ad;
    logic [CMD_W-1:0] cmd;
    logic             oe;
    logic             valid_n;
    logic             owner_n;
    logic             proc_bus_request_n_n;
  } sbh_pin_out_s;

  localparam int PIN_IN_W = AD_W + CMD_W + 3;

  // strobe inputs idle high (deasserted), address/data and command zero, while the capture stages reset
  localparam logic [PIN_IN_W-1:0] RST_PIN_IN = {{(AD_W+CMD_W){1'b0}}, 3'b111};

  function automatic logic is_data_cycle(input logic [CMD_W-1:0] cmd);
    return cmd[CMD_TYPE_BIT];
  endfunction

  function automatic logic [CMD_W-1:0] addr_cmd(input logic [CODE_W-1:0] c);
    return {1'b0, c};
  endfunction

  function automatic logic [CMD_W-1:0] data_cmd(input logic last);
    return {1'b1, (last ? LAST_DATA_ID : NOT_LAST_DATA_ID)};
  endfunction

endpackage

// ---- sbh_sync.sv ----
// two-stage capture of the pin inputs
`timescale 1ns/100ps
module sbh_sync #(
  parameter int                 W       = 8,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         arst_n_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d_in;
    next_q    = meta;
  end

  // first stage feeds only the second stage
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta  <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta  <= next_meta;
      q_out <= next_q;
    end
  end

endmodule

// ---- sbh_bus_if_sva.sv ----
// pin-level assertions for the system bus handshake block
`timescale 1ns/100ps
module sbh_bus_if_sva (
  // clock and reset
  input logic              clock_in,
  input logic              arst_n_in,
  // core side
  input logic              req_valid_in,
  input sbh_pkg::sbh_req_s req_in,
  input logic              req_ready_out,
  input logic              wr_valid_in,
  input logic [31:0]       wr_data_in,
  input logic              wr_last_in,
  input logic              wr_ready_out,
  input logic              read_pending_out,
  // pins
  input logic [31:0]       addr_data_bus_out,
  input logic              addr_data_bus_oe_out,
  input logic [4:0]        command_bus_in,
  input logic [4:0]        command_bus_out,
  input logic              proc_valid_n_out,
  input logic              ext_valid_n_in,
  input logic              ext_accept_n_in,
  input logic              ext_bus_request_n_in,
  input logic              proc_owner_n_out,
  input logic              proc_bus_request_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  logic addr_cyc;
  assign addr_cyc = !proc_valid_n_out && !command_bus_out[4];
  ////////////////////////////////////////////////////////////////////////////
  // three samples cover the two-stage input capture
  sequence s_no_grant; (ext_accept_n_in && ext_bus_request_n_in) [*3];
  endsequence
  sequence s_grant; (!ext_accept_n_in) [*3]; endsequence
  sequence s_ext_last; ext_bus_request_n_in [*3] ##0 proc_owner_n_out &&
    !ext_valid_n_in && command_bus_in == {1'b1, sbh_pkg::LAST_DATA_ID};
  endsequence
  property p_reset; !$past(arst_n_in) |-> !proc_owner_n_out &&
    proc_valid_n_out && proc_bus_request_n_out; endproperty
  property p_addr_cmd; req_valid_in && req_ready_out |=> addr_cyc &&
    command_bus_out[3:0] == $past(req_in.code) &&
    addr_data_bus_out == $past(req_in.addr); endproperty
  property p_wdata; wr_valid_in && wr_ready_out |=> !proc_valid_n_out &&
    addr_data_bus_out == $past(wr_data_in) && command_bus_out ==
    {1'b1, $past(wr_last_in) ? sbh_pkg::LAST_DATA_ID
    : sbh_pkg::NOT_LAST_DATA_ID}; endproperty
  property p_repeat; s_no_grant ##0 addr_cyc |=> addr_cyc &&
    $stable(addr_data_bus_out); endproperty
  property p_issue; s_grant ##0 addr_cyc |=> ##[0:3] !addr_cyc; endproperty
  property p_handover; $rose(read_pending_out) |-> ##[0:1]
    (proc_owner_n_out && !addr_data_bus_oe_out); endproperty
  property p_valid; !proc_valid_n_out |-> !proc_owner_n_out &&
    addr_data_bus_oe_out; endproperty
  property p_oe; addr_data_bus_oe_out ? !proc_owner_n_out :
    (proc_owner_n_out || $past(proc_owner_n_out)); endproperty
  property p_proc_bus_request_n; !proc_bus_request_n_out |-> proc_owner_n_out; endproperty
  property p_return; s_ext_last |-> ##[1:4] !proc_owner_n_out; endproperty
  property p_one_read; read_pending_out && req_in.is_read |->
    !req_ready_out; endproperty
  a_reset: assert property (p_reset) else $error("reset levels");
  a_addr_cmd: assert property (p_addr_cmd) else $error("address");
  a_wdata: assert property (p_wdata) else $error("write data");
  a_repeat: assert property (p_repeat) else $error("repeat");
  a_issue: assert property (p_issue) else $error("issue");
  a_handover: assert property (p_handover) else $error("hand-over");
  a_valid: assert property (p_valid) else $error("valid strobe");
  a_oe: assert property (p_oe) else $error("bus enable");
  a_proc_bus_request_n: assert property (p_proc_bus_request_n) else $error("bus request");
  a_return: assert property (p_return) else $error("return");
  a_one_read: assert property (p_one_read) else $error("read");
endmodule
bind sbh_bus_if sbh_bus_if_sva sbh_bus_if_sva_inst (.*);

// ---- sbh_agent.sv ----
// external agent model: paces accept and answers in slave state
`timescale 1ns/100ps
module sbh_agent (
  input  wire logic       clock_in,
  input  wire logic [7:0] acc_wait_in,
  input  wire logic       proc_valid_n_in,
  input  wire logic [4:0] proc_cmd_in,
  input  wire logic       proc_owner_n_in,
  output logic [31:0]     ad_out,
  output logic [4:0]      cmd_out,
  output logic            ext_valid_n_out,
  output logic            ext_accept_n_out
);
  int wait_cnt, held, sent, idle;
  logic addr;
  initial begin
    {ad_out, cmd_out, wait_cnt, held, sent, idle} = '0;
    {ext_valid_n_out, ext_accept_n_out} = 2'b11;
  end
  always @(negedge clock_in) begin
    addr = !proc_valid_n_in && !proc_cmd_in[4];
    // held two cycles at least and through the address cycle
    if (!ext_accept_n_out) begin
      held++;
      if (held >= 2 && !addr) begin
        ext_accept_n_out = 1'b1;
        {held, wait_cnt} = '0;
      end
    end else if (addr) begin
      if (wait_cnt >= acc_wait_in) ext_accept_n_out = 1'b0;
      else wait_cnt++;
    end else wait_cnt = 0;
    if (proc_owner_n_in) idle++;
    else {idle, sent} = '0;
    // first drive one cycle after the owner release
    if (idle >= 2 && sent < 2) begin
      ad_out = 32'hc0de_0000 + sent;
      cmd_out = {1'b1, sent == 1 ? sbh_pkg::LAST_DATA_ID
                 : sbh_pkg::NOT_LAST_DATA_ID};
      ext_valid_n_out = 1'b0;
      sent++;
    end else begin
      // released lines keep changing so a stale value cannot pass
      ext_valid_n_out = 1'b1;
      ad_out = ~ad_out;
      cmd_out = ~cmd_out;
    end
  end
endmodule

// ---- test_sbh_bus_if.sv ----
// self-checking bench for the system bus handshake block
`timescale 1ns/100ps
module test_sbh_bus_if;
  logic              clock_in, arst_n_in, req_valid_in, req_ready_out;
  sbh_pkg::sbh_req_s req_in;
  logic              wr_valid_in, wr_last_in, wr_ready_out;
  logic [31:0]       wr_data_in, rsp_data_out, agent_ad;
  logic              rsp_valid_out, rsp_last_out, rsp_error_out;
  logic              slave_state_out, read_pending_out;
  logic [31:0]       addr_data_bus_in, addr_data_bus_out;
  logic              addr_data_bus_oe_out, command_bus_oe_out;
  logic [4:0]        command_bus_in, command_bus_out, agent_cmd;
  logic              proc_valid_n_out, ext_valid_n_in, ext_accept_n_in;
  logic              ext_bus_request_n_in, proc_owner_n_out;
  logic              proc_bus_request_n_out;
  logic [7:0]        acc_wait;
  int                err_count, tests_run;
  assign addr_data_bus_in = addr_data_bus_oe_out ? addr_data_bus_out
                            : agent_ad;
  assign command_bus_in = command_bus_oe_out ? command_bus_out : agent_cmd;
  sbh_bus_if sbh_bus_if_inst (.*);
  sbh_agent sbh_agent_inst (
    .clock_in        (clock_in),
    .acc_wait_in     (acc_wait),
    .proc_valid_n_in (proc_valid_n_out),
    .proc_cmd_in     (command_bus_out),
    .proc_owner_n_in (proc_owner_n_out),
    .ad_out          (agent_ad),
    .cmd_out         (agent_cmd),
    .ext_valid_n_out (ext_valid_n_in),
    .ext_accept_n_out(ext_accept_n_in)
  );
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_owner(input logic lvl);
    for (int i = 0; i < 40 && proc_owner_n_out !== lvl; i++)
      @(negedge clock_in);
    chk(proc_owner_n_out, lvl);
  endtask
  task automatic send_req(input logic rd, input logic [3:0] code,
                          input logic [31:0] addr);
    req_in = {rd, code, addr};
    req_valid_in = 1'b1;
    for (int i = 0; i < 40 && req_ready_out !== 1'b1; i++)
      @(negedge clock_in);
    @(negedge clock_in);
    req_valid_in = 1'b0;
    chk(proc_valid_n_out, 0);
    chk(command_bus_out, {1'b0, code});
    chk(addr_data_bus_out, addr);
  endtask
  task automatic addr_phase(input int min_len, input logic [31:0] addr);
    int n;
    n = 0;
    while (n < 300 && proc_valid_n_out === 1'b0 && !command_bus_out[4]) begin
      chk(addr_data_bus_out, addr);
      n++;
      @(negedge clock_in);
    end
    chk(n >= min_len && n < 300, 1);
  endtask
  task automatic wr_words(input int n);
    for (int w = 0; w < n; w++) begin
      wr_valid_in = 1'b1;
      wr_data_in = 32'h5a00_0000 + w;
      wr_last_in = (w == n - 1);
      for (int i = 0; i < 40 && wr_ready_out !== 1'b1; i++)
        @(negedge clock_in);
      @(negedge clock_in);
      chk(command_bus_out, {1'b1, w == n - 1 ? sbh_pkg::LAST_DATA_ID
          : sbh_pkg::NOT_LAST_DATA_ID});
      chk(addr_data_bus_out, 32'h5a00_0000 + w);
    end
    wr_valid_in = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write();
    acc_wait = 8'h04;
    send_req(1'b0, 4'h7, 32'h1000_0040);
    addr_phase(5, 32'h1000_0040);
    wr_words(3);
    repeat (3) @(negedge clock_in);
    chk({proc_valid_n_out, proc_owner_n_out}, 2'b10);
    $display("write test done");
  endtask
  task automatic t_read();
    int n;
    acc_wait = 8'h00;
    send_req(1'b1, 4'h3, 32'h2000_0080);
    wait_owner(1'b1);
    chk({addr_data_bus_oe_out, read_pending_out, req_ready_out}, 3'b010);
    chk({slave_state_out, command_bus_oe_out}, 2'b10);
    n = 0;
    for (int i = 0; i < 30 && n < 2; i++) begin
      @(negedge clock_in);
      if (rsp_valid_out === 1'b1) begin
        chk(rsp_data_out, 32'hc0de_0000 + n);
        chk({rsp_last_out, rsp_error_out}, {n == 1, 1'b0});
        n++;
      end
    end
    chk(n, 2);
    wait_owner(1'b0);
    chk(read_pending_out, 0);
    $display("read test done");
  endtask
  task automatic t_arb();
    acc_wait = 8'hff;
    send_req(1'b0, 4'h5, 32'h3000_0100);
    repeat (3) @(negedge clock_in);
    ext_bus_request_n_in = 1'b0;
    wait_owner(1'b1);
    ext_bus_request_n_in = 1'b1;
    repeat (2) @(negedge clock_in);
    chk({proc_bus_request_n_out, proc_valid_n_out}, 2'b01);
    wait_owner(1'b0);
    acc_wait = 8'h01;
    for (int i = 0; i < 40 && proc_valid_n_out !== 1'b0; i++)
      @(negedge clock_in);
    addr_phase(2, 32'h3000_0100);
    wr_words(1);
    chk({slave_state_out, command_bus_oe_out}, 2'b01);
    $display("arbitration test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n_in, req_valid_in, req_in, wr_valid_in} = '0;
    {wr_data_in, wr_last_in, acc_wait, err_count, tests_run} = '0;
    ext_bus_request_n_in = 1'b1;
    repeat (8) @(negedge clock_in);
    chk({proc_owner_n_out, proc_valid_n_out, proc_bus_request_n_out,
         addr_data_bus_oe_out}, 4'h7);
    arst_n_in = 1'b1;
    @(negedge clock_in);
    t_write();
    t_read();
    t_arb();
    stop_test();
  end
  initial begin
    repeat (4000) @(posedge clock_in);
    err_count++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end
endmodule
